// File: rtl/gpd_consts.vh
// register offsets, field positions, codes and reset values of the port slice
`ifndef GPD_CONSTS_VH
`define GPD_CONSTS_VH
`define GPD_ADDR_W 4
`define GPD_OFS_DRIVE_LEVEL 4'h4
`define GPD_OFS_DRIVE_LEVEL_SET 4'h5
`define GPD_OFS_DRIVE_LEVEL_CLEAR 4'h6
`define GPD_OFS_DRIVE_LEVEL_TOGGLE 4'h7
`define GPD_OFS_SAMPLED_PIN_LEVELS 4'h8
`define GPD_OFS_PIN_EVENT_FLAGS 4'h9
`define GPD_OFS_PORT_SLEW_CONTROL 4'hA
`define GPD_OFS_EVENT_MASK 4'hF
`define GPD_SLEW_BIT 0
`define GPD_RST_BYTE 8'h00
`define GPD_RST_MASK 8'hFF
`define GPD_SENSE_NONE 3'h0
`define GPD_SENSE_BOTH 3'h1
`define GPD_SENSE_RISE 3'h2
`define GPD_SENSE_FALL 3'h3
`define GPD_SENSE_BUF_OFF 3'h4
`define GPD_SENSE_LOW 3'h5
`endif

// File: rtl/gpd_pin_sync.v
// three-flop synchroniser; output changes once stages two and three agree
module gpd_pin_sync #(
   parameter WIDTH = 8
) (
   input wire clock,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {WIDTH{1'b0}};
         s2_q <= {WIDTH{1'b0}};
         s3_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // per bit: one restless pin must not starve the others
         sync_out <= (sync_out & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      end
   end
endmodule

// File: rtl/gpd_port.v
// eight-pin port slice: drive level, input sampling, event flags, slew
// What this block does
// - drive level bit sets pin high or low
// - level reaches pin only with driver enabled
// - set alias sets bits written one
// - clear alias clears bits written one
// - toggle alias inverts bits written one
// - alias reads return drive level
// - input state shows pin level, buffer on
// - writing input state toggles drive level
// - buffer off holds input state bit
// - event flag set on matching sense condition
// - writing one clears event flag
// - slew control bit zero limits all pins
// - drive enable one turns driver on
// - sense select codes pick event kind
// - low level keeps setting the flag
// - invert enable flips output and input
`include "gpd_consts.vh"
module gpd_port #(
   parameter PINS = 8
) (
   input wire clock,
   input wire rst_n,
   input wire [`GPD_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   input wire [PINS-1:0] drive_enable,
   input wire [PINS-1:0] invert_enable,
   input wire [3*PINS-1:0] sense_select,
   input wire [PINS-1:0] pin_in,
   output wire [PINS-1:0] pin_out,
   output wire [PINS-1:0] pin_oe_n,
   output wire slew_limit_enable,
   output wire irq
);
   reg [PINS-1:0] drive_level_q;
   reg [PINS-1:0] drive_level_d;
   reg [PINS-1:0] sampled_q;
   reg [PINS-1:0] prev_q;
   reg [PINS-1:0] flags_q;
   reg [PINS-1:0] mask_q;
   reg slew_q;
   wire [PINS-1:0] pin_sync;
   wire [PINS-1:0] buf_on;
   wire [PINS-1:0] hit;
   wire [PINS-1:0] logic_in;
   wire wr_lvl;
   wire wr_set;
   wire wr_clr;
   wire wr_tgl;
   wire wr_in;
   wire wr_flag;
   wire wr_slew;
   wire wr_mask;

   assign wr_lvl = reg_write && (reg_addr == `GPD_OFS_DRIVE_LEVEL);
   assign wr_set = reg_write && (reg_addr == `GPD_OFS_DRIVE_LEVEL_SET);
   assign wr_clr = reg_write && (reg_addr == `GPD_OFS_DRIVE_LEVEL_CLEAR);
   assign wr_tgl = reg_write && (reg_addr == `GPD_OFS_DRIVE_LEVEL_TOGGLE);
   assign wr_in = reg_write && (reg_addr == `GPD_OFS_SAMPLED_PIN_LEVELS);
   assign wr_flag = reg_write && (reg_addr == `GPD_OFS_PIN_EVENT_FLAGS);
   assign wr_slew = reg_write && (reg_addr == `GPD_OFS_PORT_SLEW_CONTROL);
   assign wr_mask = reg_write && (reg_addr == `GPD_OFS_EVENT_MASK);

   gpd_pin_sync #(
      .WIDTH(PINS)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   assign logic_in = pin_sync ^ invert_enable;

   always @* begin
      drive_level_d = drive_level_q;
      if (wr_lvl) begin
         drive_level_d = reg_wdata[PINS-1:0];
      end
      if (wr_set) begin
         drive_level_d = drive_level_q | reg_wdata[PINS-1:0];
      end
      if (wr_clr) begin
         drive_level_d = drive_level_q & ~reg_wdata[PINS-1:0];
      end
      // toggle via alias or input state
      if (wr_tgl || wr_in) begin
         drive_level_d = drive_level_q ^ reg_wdata[PINS-1:0];
      end
   end

   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         wire [2:0] sel;
         assign sel = sense_select[3*i+2:3*i];
         // buffer off only for this code
         assign buf_on[i] = (sel != `GPD_SENSE_BUF_OFF);
         assign hit[i] =
            (sel == `GPD_SENSE_BOTH && logic_in[i] != prev_q[i]) ||
            (sel == `GPD_SENSE_RISE && logic_in[i] && !prev_q[i]) ||
            (sel == `GPD_SENSE_FALL && !logic_in[i] && prev_q[i]) ||
            (sel == `GPD_SENSE_LOW && !logic_in[i]);
      end
   endgenerate

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drive_level_q <= `GPD_RST_BYTE;
         sampled_q <= `GPD_RST_BYTE;
         prev_q <= `GPD_RST_BYTE;
         flags_q <= `GPD_RST_BYTE;
         mask_q <= `GPD_RST_MASK;
         slew_q <= 1'b0;
      end else begin
         drive_level_q <= drive_level_d;
         sampled_q <= (logic_in & buf_on) | (sampled_q & ~buf_on);
         prev_q <= logic_in;
         flags_q <= (flags_q & ~(wr_flag ? reg_wdata[PINS-1:0] :
                    {PINS{1'b0}})) | hit;
         if (wr_mask) begin
            mask_q <= reg_wdata[PINS-1:0];
         end
         if (wr_slew) begin
            slew_q <= reg_wdata[`GPD_SLEW_BIT];
         end
      end
   end

   assign pin_out = drive_level_q ^ invert_enable;
   assign pin_oe_n = ~drive_enable;
   assign slew_limit_enable = slew_q;
   assign irq = |(flags_q & mask_q);

   // one-cycle read latency; unmapped reads give zero
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            `GPD_OFS_DRIVE_LEVEL, `GPD_OFS_DRIVE_LEVEL_SET,
            `GPD_OFS_DRIVE_LEVEL_CLEAR, `GPD_OFS_DRIVE_LEVEL_TOGGLE: begin
               reg_rdata <= drive_level_q;
            end
            `GPD_OFS_SAMPLED_PIN_LEVELS: begin
               reg_rdata <= sampled_q;
            end
            `GPD_OFS_PIN_EVENT_FLAGS: begin
               reg_rdata <= flags_q;
            end
            `GPD_OFS_PORT_SLEW_CONTROL: begin
               reg_rdata <= {7'h00, slew_q};
            end
            `GPD_OFS_EVENT_MASK: begin
               reg_rdata <= mask_q;
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// File: testbench/gpd_pads.sv
// partner: pad levels seen from outside the package
module gpd_pads (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// File: testbench/gpd_port_asserts.sv
// checker: register and pin relations of the port slice
module gpd_port_asserts (
   input wire logic clock, rst_n, reg_write, reg_read,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata, pin_out, pin_oe_n,
   input wire logic [7:0] drive_enable, invert_enable,
   input wire logic slew_limit_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // stored level seen through the invert stage
   wire [7:0] lvl = pin_out ^ invert_enable;
   wire [4:0] wa = {reg_write, reg_addr};
   property p_oe; pin_oe_n == ~drive_enable; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_wr; wa == 5'h14 |=> lvl == $past(reg_wdata); endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_set; wa == 5'h15 |=> lvl == ($past(lvl) | $past(reg_wdata));
   endproperty
   a_set: assert property (p_set) else $error("set");
   property p_clr; wa == 5'h16 |=> lvl == ($past(lvl) & ~$past(reg_wdata));
   endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_tgl; wa == 5'h17 || wa == 5'h18 |=>
      lvl == ($past(lvl) ^ $past(reg_wdata)); endproperty
   a_tgl: assert property (p_tgl) else $error("tgl");
   property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_ard; reg_read && reg_addr[3:2] == 2'b01 |=>
      reg_rdata == $past(lvl); endproperty
   a_ard: assert property (p_ard) else $error("ard");
   property p_slw; wa == 5'h1A |=>
      slew_limit_enable == $past(reg_wdata[0]); endproperty
   a_slw: assert property (p_slw) else $error("slw");
endmodule

// File: testbench/gpio_port_data_and_flags_tb_top.sv
// bench: port slice against a reference model
module gpio_port_data_and_flags_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, de = 0, inv = 0, ext = 0;
   logic [7:0] reg_rdata, pin_out, pin_oe_n, pin;
   logic [23:0] ss = 0;
   logic slew_limit_enable, irq;
   int n_fail = 0, tests_run = 0, lvl = 0;
   always #4 clock = ~clock;
   gpd_port gpd_port_i (.*, .drive_enable(de), .invert_enable(inv),
      .sense_select(ss), .pin_in(pin));
   gpd_pads gpd_pads_i (.*, .ext_level(ext), .pin_level(pin));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %0t %h %h", $time, g, e);
      end
   endtask
   task automatic acc(input bit w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge clock);
      {reg_write, reg_read} <= 2'b00;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input int e);
      acc(0, a, 8'h00);
      chk(reg_rdata, e[7:0]);
   endtask
   task automatic wrt(input logic [3:0] a, input logic [7:0] d);
      acc(1, a, d);
      case (a)
         4'h4: lvl = d;
         4'h5: lvl |= d;
         4'h6: lvl &= ~d;
         4'h7, 4'h8: lvl ^= d;
      endcase
   endtask
   // synchroniser plus flag stage settle in five of these six cycles
   task automatic pause;
      repeat (6) @(posedge clock);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      void'($urandom(97));
      repeat (12) @(posedge clock);
      rst_n <= 1;
      repeat (30) begin
         de <= 8'($urandom);
         inv <= 8'($urandom);
         wrt(4'($urandom % 5 + 4), 8'($urandom));
         rdc(4'($urandom % 4 + 4), lvl);
         chk(pin_out, lvl[7:0] ^ inv);
         chk(~pin_oe_n, de);
      end
      $display("alias test done");
      de <= 0;
      ext <= 8'($urandom);
      pause();
      rdc(4'h8, ext ^ inv);
      ss <= 24'h924924;
      ext <= ~ext;
      pause();
      rdc(4'h8, ~ext ^ inv);
      $display("input test done");
      inv <= 0;
      for (int c = 0; c < 8; c++) begin
         ss <= {8{3'(c)}};
         ext <= 0;
         pause();
         wrt(4'h9, 8'hFF);
         ext <= 8'hFF;
         pause();
         ext <= 0;
         pause();
         rdc(4'h9, (c % 4 && c < 6) ? 8'hFF : 8'h00);
         chk(irq, 8'(c % 4 && c < 6));
      end
      $display("event test done");
      ss <= 24'h249249;
      ext <= 8'hFF;
      pause();
      wrt(4'h9, 8'h0F);
      rdc(4'h9, 8'hF0);
      wrt(4'hA, 8'h01);
      chk(slew_limit_enable, 8'h01);
      rdc(4'h3, 0);
      wrt(4'hF, 8'h00);
      chk(irq, 8'h00);
      rdc(4'hF, 8'h00);
      wrt(4'hF, 8'h10);
      chk(irq, 8'h01);
      $display("control test done");
      finish_test();
   end
endmodule
bind gpd_port gpd_port_asserts gpd_port_asserts_i (.*);
